// File: qpd_pkg.sv
package qpd_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses on the AXI4-Lite port
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 4;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_MASK    = 4'h8;
  localparam logic [3:0]  REG_COUNT   = 4'hc;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_RES_LSB = 0;
  localparam int unsigned CTRL_CLR_BIT = 2;
  localparam int unsigned STAT_OVF     = 0;
  localparam int unsigned STAT_UDF     = 1;
  localparam int unsigned STAT_IDX     = 2;
  localparam int unsigned STAT_INV     = 3;
  localparam int unsigned STAT_W       = 4;

  // ---------------------------------------------------------------
  // Modes and reset values
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    QPD_RES_1X = 2'b00,
    QPD_RES_2X = 2'b01,
    QPD_RES_4X = 2'b10
  } qpd_res_t;

  localparam qpd_res_t            RES_RST  = QPD_RES_4X;
  localparam logic [STAT_W-1:0]   MASK_RST = 4'hf;
  localparam int unsigned         EXT_W    = 16;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: qpd_decoder.sv
`timescale 1ns/10ps
// Overview of operation
// - Counter width built as 8, 16 or 32
// - Counter holds signed two's complement position
// - Counts per input period: one, two, four
// - Phases decoded as Gray sequence for direction
// - Count up one way, down the other
// - Index with both phases low clears counter
// - Index use is a build-time option
// - All inputs sampled on the single clock
// - Glitch filtering is a build-time option
// - Filter output moves after three agreeing samples
// - Interrupt on counter overflow or underflow
// - Interrupt when index clears the counter
// - Interrupt on illegal phase transition
// - Wide build keeps sixteen bits, reports wraps
// - Filtering applies to phases and index alike
// - Filtering enabled by default
// - Index use enabled by default
module qpd_decoder
  import qpd_pkg::*;
#(
  parameter int unsigned CNT_W      = 8,
  parameter bit          USE_INDEX  = 1'b1,
  parameter bit          USE_FILTER = 1'b1
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               quad_a,
  input  wire logic               quad_b,
  input  wire logic               quad_index,
  output logic                    irq,
  output logic [31:0]             position,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // the wide build keeps only the low half in hardware
  localparam int unsigned HW_W = (CNT_W == 32) ? EXT_W : CNT_W;
  localparam logic [HW_W-1:0] CNT_MAX = {1'b0, {(HW_W-1){1'b1}}};
  localparam logic [HW_W-1:0] CNT_MIN = {1'b1, {(HW_W-1){1'b0}}};

  if (!(CNT_W == 8 || CNT_W == 16 || CNT_W == 32)) begin : g_bad_width
    $error("qpd_decoder: CNT_W must be 8, 16 or 32");
  end

  // ---------------------------------------------------------------
  // Input sampling and glitch filter, bit order {index, b, a}
  // ---------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] hist0_q;
  logic [2:0] hist1_q;
  logic [2:0] filt_q;
  logic [2:0] filt_d;
  logic [2:0] in_f;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      hist0_q <= 3'h7;
      hist1_q <= 3'h7;
      filt_q  <= 3'h7;
    end else begin
      sync1_q <= {quad_index, quad_b, quad_a};
      sync2_q <= sync1_q;
      hist0_q <= sync2_q;
      hist1_q <= hist0_q;
      filt_q  <= filt_d;
    end
  end

  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < 3; i++) begin
      // A level is taken only once three samples in a row agree
      if (sync2_q[i] == hist0_q[i] && hist0_q[i] == hist1_q[i]) begin
        filt_d[i] = sync2_q[i];
      end
    end
    in_f = USE_FILTER ? filt_q : sync2_q;
    if (!USE_INDEX) begin
      in_f[2] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bus side state
  // ---------------------------------------------------------------
  logic              aw_have_q, aw_have_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic              w_have_q,  w_have_d;
  logic [31:0]       w_data_q,  w_data_d;
  logic              w_lane0_q, w_lane0_d;
  logic              bvalid_q,  bvalid_d;
  logic [1:0]        bresp_q,   bresp_d;
  logic              rvalid_q,  rvalid_d;
  logic [1:0]        rresp_q,   rresp_d;
  logic [31:0]       rdata_q,   rdata_d;
  logic              wr_go;

  // ---------------------------------------------------------------
  // Decoder state
  // ---------------------------------------------------------------
  logic [1:0]        prev_q,   prev_d;
  logic [HW_W-1:0]   cnt_q,    cnt_d;
  logic [STAT_W-1:0] sts_q,    sts_d;
  logic [STAT_W-1:0] mask_q,   mask_d;
  qpd_res_t          res_q,    res_d;
  logic              irq_q,    irq_d;
  logic              a_chg, b_chg, inv, up, step, idx_hit, sw_clr;
  logic [STAT_W-1:0] w1c, ev;
  logic [31:0]       cnt_ext;

  assign wr_go   = aw_have_q & w_have_q & ~bvalid_q;
  assign cnt_ext = {{(32-HW_W){cnt_q[HW_W-1]}}, cnt_q};

  always_comb begin
    prev_d = in_f[1:0];
    a_chg  = in_f[0] ^ prev_q[0];
    b_chg  = in_f[1] ^ prev_q[1];
    inv    = a_chg & b_chg;
    up     = prev_q[0] ^ in_f[1];
    case (res_q)
      QPD_RES_4X: step = ~inv & (a_chg | b_chg);
      QPD_RES_2X: step = ~inv & a_chg;
      default:    step = ~inv & a_chg & in_f[0];
    endcase
    idx_hit = USE_INDEX && (in_f == 3'h0);
    sw_clr  = 1'b0;
    w1c     = '0;
    res_d   = res_q;
    mask_d  = mask_q;
    if (wr_go && w_lane0_q) begin
      if (aw_addr_q == REG_CTRL) begin
        sw_clr = w_data_q[CTRL_CLR_BIT];
        case (w_data_q[CTRL_RES_LSB +: 2])
          2'b00:   res_d = QPD_RES_1X;
          2'b01:   res_d = QPD_RES_2X;
          default: res_d = QPD_RES_4X;
        endcase
      end else if (aw_addr_q == REG_STATUS) begin
        w1c = w_data_q[STAT_W-1:0];
      end else if (aw_addr_q == REG_MASK) begin
        mask_d = w_data_q[STAT_W-1:0];
      end
    end
    ev = '0;
    cnt_d = cnt_q;
    if (idx_hit || sw_clr) begin
      cnt_d = '0;
      ev[STAT_IDX] = idx_hit;
    end else if (step) begin
      if (up) begin
        cnt_d = HW_W'(cnt_q + 1'b1);
        ev[STAT_OVF] = (cnt_q == CNT_MAX);
      end else begin
        cnt_d = HW_W'(cnt_q - 1'b1);
        ev[STAT_UDF] = (cnt_q == CNT_MIN);
      end
    end
    ev[STAT_INV] = inv;
    // A new event beats a clear written in the same cycle
    sts_d = (sts_q & ~w1c) | ev;
    irq_d = |(sts_d & mask_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 2'h3;
      cnt_q  <= '0;
      sts_q  <= '0;
      mask_q <= MASK_RST;
      res_q  <= RES_RST;
      irq_q  <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      sts_q  <= sts_d;
      mask_q <= mask_d;
      res_q  <= res_d;
      irq_q  <= irq_d;
    end
  end

  assign irq = irq_q;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_lane0_d = w_lane0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d  = 1'b1;
      w_data_d  = s_axi_wdata;
      w_lane0_d = s_axi_wstrb[0];
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (aw_addr_q == REG_COUNT || aw_addr_q[1:0] != 2'b00) ? RESP_SLVERR
                                                                      : RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        rdata_d = 32'(res_q);
      end else if (s_axi_araddr == REG_STATUS) begin
        rdata_d = 32'(sts_q);
      end else if (s_axi_araddr == REG_MASK) begin
        rdata_d = 32'(mask_q);
      end else if (s_axi_araddr == REG_COUNT) begin
        rdata_d = cnt_ext;
      end else begin
        rdata_d = 32'h0;
        rresp_d = RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0;
      position  <= 32'h0;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_lane0_q <= w_lane0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      position  <= {{(32-HW_W){cnt_d[HW_W-1]}}, cnt_d};
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_plain_step_up;
    step && up && !idx_hit && !sw_clr;
  endsequence
  sequence s_plain_step_dn;
    step && !up && !idx_hit && !sw_clr;
  endsequence

  a_index_clear: assert property (idx_hit |=> cnt_q == '0 && sts_q[STAT_IDX])
    else $error("index condition did not clear the counter");
  a_count_up: assert property (s_plain_step_up |=> cnt_q == HW_W'($past(cnt_q) + 1'b1))
    else $error("counter did not step up by one");
  a_count_down: assert property (s_plain_step_dn |=> cnt_q == HW_W'($past(cnt_q) - 1'b1))
    else $error("counter did not step down by one");
  a_invalid_hold: assert property (a_chg && b_chg && !idx_hit && !sw_clr
                                   |=> $stable(cnt_q) && sts_q[STAT_INV])
    else $error("double phase change moved the counter");
  a_wrap_flag: assert property (s_plain_step_up and cnt_q == CNT_MAX
                                |=> cnt_q == CNT_MIN && sts_q[STAT_OVF])
    else $error("overflow wrap not reported");
  a_res_edges: assert property (res_q != QPD_RES_4X && !a_chg && !idx_hit && !sw_clr
                                |=> $stable(cnt_q))
    else $error("counter moved on a phase edge outside resolution");
  a_irq_follow: assert property (|(ev & mask_d) |=> irq_q)
    else $error("unmasked event did not raise the interrupt");
  a_irq_quiet: assert property (ev == '0 && (sts_q & mask_d) == '0 |=> !irq_q)
    else $error("interrupt high with no pending status");
  if (USE_FILTER) begin : g_filt_chk
    a_filter_agree: assert property ($changed(filt_q[0]) |->
        $past(sync2_q[0], 1) == filt_q[0] && $past(sync2_q[0], 2) == filt_q[0]
        && $past(sync2_q[0], 3) == filt_q[0])
      else $error("filter changed without three agreeing samples");
  end

endmodule // qpd_decoder

// File: qpd_enc_model.sv
`timescale 1ns/10ps
module qpd_enc_model (
  input  wire logic clk,
  output logic      quad_a,
  output logic      quad_b,
  output logic      quad_index
);
  logic [1:0] pos    = 2'h2;
  bit         idx_en = 1'b0;

  initial {quad_a, quad_b, quad_index} = 3'h7;

  // Gray position, one phase moves per step; hold keeps clk above ten times the phase rate
  task automatic drive(input logic [1:0] p);
    pos = p;
    quad_a <= p[1];
    quad_b <= p[1] ^ p[0];
    quad_index <= !(idx_en && p == 2'h0);
    repeat (10) @(posedge clk);
  endtask

  task automatic step(input bit up);
    @(posedge clk);
    drive(up ? pos + 2'h1 : pos - 2'h1);
  endtask

  // Both phases move at once, an illegal transition
  task automatic jump();
    @(posedge clk);
    drive(pos + 2'h2);
  endtask

  // Two-cycle pulse, shorter than the filter window
  task automatic glitch(input bit on_index);
    @(posedge clk);
    if (on_index) quad_index <= 1'b0;
    else quad_a <= !quad_a;
    repeat (2) @(posedge clk);
    if (on_index) quad_index <= 1'b1;
    else quad_a <= pos[1];
    repeat (10) @(posedge clk);
  endtask
endmodule // qpd_enc_model

// File: quadrature_position_decoder_tb_top.sv
`timescale 1ns/10ps
module quadrature_position_decoder_tb_top
  import qpd_pkg::*;
();
  logic              clk     = 1'b0;
  logic              rst     = 1'b1;
  logic              qa, qb, qi, irq;
  logic [31:0]       position;
  logic [ADDR_W-1:0] awaddr  = 4'h0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [31:0]       wdata   = 32'h0;
  logic [3:0]        wstrb   = 4'hf;
  logic              irq2;
  logic [31:0]       position2;
  logic              wvalid  = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready  = 1'b0;
  logic [ADDR_W-1:0] araddr  = 4'h0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready  = 1'b0;
  logic [1:0]        rsp;
  logic [31:0]       rd;
  int                errors  = 0;
  int                checks  = 0;
  int                cycles  = 0;

  // Default build: filter and index both on
  qpd_decoder i_qpd_decoder (
    .clk(clk), .rst(rst), .quad_a(qa), .quad_b(qb), .quad_index(qi), .irq(irq),
    .position(position), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  qpd_enc_model i_qpd_enc_model (.clk(clk), .quad_a(qa), .quad_b(qb), .quad_index(qi));

  // Wide build with no filter and no index; it shares the bus writes, the
  // first instance's handshake paces both since the bus logic is the same
  qpd_decoder #(.CNT_W(32), .USE_INDEX(1'b0), .USE_FILTER(1'b0)) i_qpd_decoder_wide (
    .clk(clk), .rst(rst), .quad_a(qa), .quad_b(qb), .quad_index(qi), .irq(irq2),
    .position(position2), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      complete_run();
    end
  end

  // ------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------
  task automatic complete_run();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string s);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %b", $time, s, got);
    end
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    write_reg(a, d, rsp);
    check_word({30'h0, rsp}, {30'h0, RESP_OKAY}, "bresp");
  endtask

  task automatic expect_reg(input logic [3:0] a, input logic [31:0] exp);
    read_reg(a, rd, rsp);
    check_word(rd, exp, "rdata");
    check_word({30'h0, rsp}, {30'h0, RESP_OKAY}, "rresp");
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_defaults();
    expect_reg(REG_CTRL, {30'h0, RES_RST});
    expect_reg(REG_MASK, {28'h0, MASK_RST});
    expect_reg(REG_STATUS, 32'h0);
    expect_reg(REG_COUNT, 32'h0);
    check_bit(irq, 1'b0, "irq idle");
    read_reg(4'h2, rd, rsp);
    check_word(rd, 32'h0, "unaligned");
    check_word({30'h0, rsp}, {30'h0, RESP_SLVERR}, "rresp");
    write_reg(REG_COUNT, 32'h5, rsp);
    check_word({30'h0, rsp}, {30'h0, RESP_SLVERR}, "bresp");
    expect_reg(REG_COUNT, 32'h0);
    // Byte lane 0 off: accepted but ignored
    wstrb <= 4'h0;
    wr(REG_MASK, 32'h0);
    wstrb <= 4'hf;
    expect_reg(REG_MASK, {28'h0, MASK_RST});
  endtask

  task automatic t_direction();
    wr(REG_CTRL, 32'h6);
    repeat (5) i_qpd_enc_model.step(1'b1);
    check_word(position, 32'h5, "up");
    check_word(position2, 32'h5, "wide up");
    repeat (2) i_qpd_enc_model.step(1'b0);
    expect_reg(REG_COUNT, 32'h3);
  endtask

  task automatic t_resolution();
    for (int r = 0; r < 3; r++) begin
      wr(REG_CTRL, 32'h4 | r);
      repeat (4) i_qpd_enc_model.step(1'b1);
      check_word(position, 32'h1 << r, "per period");
      check_word(position2, 32'h1 << r, "wide per period");
    end
  endtask

  task automatic t_wrap();
    wr(REG_CTRL, 32'h6);
    wr(REG_STATUS, 32'hf);
    repeat (127) i_qpd_enc_model.step(1'b1);
    check_word(position, 32'h7f, "max");
    expect_reg(REG_STATUS, 32'h0);
    i_qpd_enc_model.step(1'b1);
    check_word(position, 32'hffffff80, "wrap");
    check_word(position2, 32'h80, "wide no wrap");
    check_bit(irq2, 1'b0, "wide irq quiet");
    expect_reg(REG_STATUS, 32'h1);
    check_bit(irq, 1'b1, "irq ovf");
    wr(REG_STATUS, 32'h1);
    expect_reg(REG_STATUS, 32'h0);
    check_bit(irq, 1'b0, "irq clear");
    i_qpd_enc_model.step(1'b0);
    check_word(position, 32'h7f, "unwrap");
    check_word(position2, 32'h7f, "wide down");
    expect_reg(REG_STATUS, 32'h2);
    wr(REG_STATUS, 32'hf);
  endtask

  task automatic t_filter_index();
    int n;
    n = 1;
    wr(REG_CTRL, 32'h6);
    i_qpd_enc_model.step(1'b1);
    while (i_qpd_enc_model.pos != 2'h0) begin
      i_qpd_enc_model.step(1'b1);
      n++;
    end
    i_qpd_enc_model.glitch(1'b0);
    check_word(position, 32'(n), "glitch a");
    check_word(position2, 32'(n), "wide glitch a");
    i_qpd_enc_model.glitch(1'b1);
    check_word(position, 32'(n), "glitch idx");
    expect_reg(REG_STATUS, 32'h0);
    i_qpd_enc_model.idx_en = 1'b1;
    repeat (4) i_qpd_enc_model.step(1'b1);
    check_word(position, 32'h0, "index");
    check_word(position2, 32'(n + 4), "wide no index");
    expect_reg(REG_STATUS, 32'h4);
    check_bit(irq, 1'b1, "irq idx");
    check_bit(irq2, 1'b0, "wide irq idx");
    i_qpd_enc_model.step(1'b1);
    check_word(position, 32'h1, "after index");
    check_word(position2, 32'(n + 5), "wide after index");
    i_qpd_enc_model.idx_en = 1'b0;
    wr(REG_STATUS, 32'hf);
  endtask

  task automatic t_invalid();
    logic [31:0] p;
    logic [31:0] p2;
    wr(REG_MASK, 32'h0);
    wr(REG_STATUS, 32'hf);
    p = position;
    p2 = position2;
    i_qpd_enc_model.jump();
    check_word(position, p, "held");
    check_word(position2, p2, "wide held");
    expect_reg(REG_STATUS, 32'h8);
    check_bit(irq, 1'b0, "masked");
    wr(REG_MASK, 32'h8);
    expect_reg(REG_MASK, 32'h8);
    check_bit(irq, 1'b1, "irq inv");
    check_bit(irq2, 1'b1, "wide irq inv");
    wr(REG_STATUS, 32'hf);
    wr(REG_MASK, 32'hf);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_direction();
    t_resolution();
    t_wrap();
    t_filter_index();
    t_invalid();
    complete_run();
  end
endmodule // quadrature_position_decoder_tb_top
